// file: logic/lin_gate_pkg.sv
// Constants, register map and types shared by the receive gate design.
package lin_gate_pkg;
   // ****************************************************************
   // Register offsets (byte addresses).
   // ****************************************************************
   localparam logic [11:0] GCR1_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] MASK_OFS = 12'h008;
   localparam logic [11:0] RXDATA_OFS = 12'h00c;
   // ****************************************************************
   // Field positions and reset values.
   // ****************************************************************
   localparam int RECEIVE_TRANSFER_ENABLE_BIT = 24;
   localparam int RUN_ON_SUSPEND_BIT = 17;
   localparam int LOOP_BIT = 16;
   localparam int HALT_BIT = 13;
   localparam int LINMODE_BIT = 6;
   localparam int ST_RXRDY = 0;
   localparam int ST_RXERR = 1;
   localparam int ST_STOP = 2;
   localparam int STAT_W = 3;
   localparam logic [STAT_W-1:0] STAT_RESET = 3'h0;
   localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;
   localparam logic [7:0] RXDATA_RESET = 8'h00;
   localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;
   // ****************************************************************
   // Timing: clock cycles per serial bit.
   // ****************************************************************
   localparam int DEF_BIT_CYCLES = 16;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_t;
endpackage

// file: logic/receive_shifter.sv
// Serial receive shift register that assembles one 8N1 character.
`timescale 1ns/1ns
module receive_shifter
   import lin_gate_pkg::*;
#(
   parameter int BIT_CYCLES = DEF_BIT_CYCLES
)
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic serial_in,
   input wire logic freeze_in,
   output logic busy_out,
   output logic done_out,
   output logic [7:0] data_out,
   output logic frame_err_out
);
   if (BIT_CYCLES < 4 || BIT_CYCLES > 65535)
   begin : g_bit_cycles_check
      $error("BIT_CYCLES out of range");
   end
   localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
   rx_state_t state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [2:0] bits_reg, bits_next;
   logic [7:0] shift_reg, shift_next, data_reg, data_next;
   logic done_reg, done_next, err_reg, err_next;
   // ****************************************************************
   // Bit sampling; a frozen shifter holds every register except the done pulse, which clears.
   // ****************************************************************
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bits_next = bits_reg;
      shift_next = shift_reg;
      data_next = data_reg;
      err_next = err_reg;
      done_next = 1'b0;
      if (!freeze_in)
      begin
         if (state_reg != RX_IDLE && cnt_reg != 16'h0000)
            cnt_next = cnt_reg - 16'h0001;
         else
         begin
            unique case (state_reg)
               RX_IDLE:
               begin
                  if (!serial_in)
                  begin
                     state_next = RX_START;
                     cnt_next = HALF_LAST;
                  end
               end
               RX_START:
               begin
                  state_next = serial_in ? RX_IDLE : RX_DATA;
                  cnt_next = BIT_LAST;
                  bits_next = 3'h0;
               end
               RX_DATA:
               begin
                  shift_next = {serial_in, shift_reg[7:1]};
                  cnt_next = BIT_LAST;
                  bits_next = bits_reg + 3'h1;
                  if (bits_reg == 3'h7)
                     state_next = RX_STOP;
               end
               RX_STOP:
               begin
                  state_next = RX_IDLE;
                  done_next = 1'b1;
                  data_next = shift_reg;
                  err_next = !serial_in;
               end
            endcase
         end
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         state_reg <= RX_IDLE;
         cnt_reg <= 16'h0000;
         bits_reg <= 3'h0;
         shift_reg <= 8'h00;
         data_reg <= 8'h00;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bits_reg <= bits_next;
         shift_reg <= shift_next;
         data_reg <= data_next;
         done_reg <= done_next;
         err_reg <= err_next;
      end
   end
   assign busy_out = (state_reg != RX_IDLE);
   assign done_out = done_reg;
   assign data_out = data_reg;
   assign frame_err_out = err_reg;
endmodule

// file: logic/lin_sci_rx_gate_loop_debug_ctrl.sv
// Receive gating, loopback, debug suspend and long-frame stop control.
`timescale 1ns/1ns
module lin_sci_rx_gate_loop_debug_ctrl
   import lin_gate_pkg::*;
#(
   parameter int BIT_CYCLES = DEF_BIT_CYCLES
)
(
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic SERIAL_IN_PIN_IN,
   output logic SERIAL_IN_PIN_OE_OUT,
   output logic SERIAL_OUT_PIN_OUT,
   input wire logic TX_SERIAL_IN,
   input wire logic TX_BUSY_IN,
   input wire logic TX_FRAME_DONE_IN,
   input wire logic LONG_FRAME_START_IN,
   input wire logic DEBUG_SUSPEND_IN,
   output logic FREEZE_OUT,
   output logic RX_BUF_WRITE_OUT,
   output logic [7:0] RX_BUF_DATA_OUT,
   output logic LONG_FRAME_ACTIVE_OUT,
   output logic IRQ_OUT
);
   logic pin_meta_reg, pin_sync_reg;
   logic rx_line, rx_busy, rx_done, rx_err, freeze;
   logic [7:0] rx_data;
   logic setup_rd, acc_wr, hit, wr_gcr1, wr_stat, wr_mask, xfer, frame_end;
   logic receive_transfer_enable_reg, receive_transfer_enable_next, run_on_suspend_reg, run_on_suspend_next, loop_reg, loop_next;
   logic lin_reg, lin_next, halt_reg, halt_next, long_reg, long_next;
   logic [STAT_W-1:0] stat_reg, stat_next, mask_reg, mask_next, stat_set, irq_gate;
   logic [7:0] rxdata_reg, rxdata_next;
   logic bufwr_reg, bufwr_next;
   logic [31:0] gcr1_rd, prdata_reg, prdata_next;

   // ****************************************************************
   // Pin synchroniser and loopback routing.
   // ****************************************************************
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
      end
      else
      begin
         pin_meta_reg <= SERIAL_IN_PIN_IN;
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign rx_line = loop_reg ? TX_SERIAL_IN : pin_sync_reg;
   assign SERIAL_OUT_PIN_OUT = loop_reg ? 1'b1 : TX_SERIAL_IN;
   assign SERIAL_IN_PIN_OE_OUT = 1'b0;

   // ****************************************************************
   // Debug suspend: freeze at once, or after transfers in progress end.
   // ****************************************************************
   assign freeze = DEBUG_SUSPEND_IN && (!run_on_suspend_reg || (!rx_busy && !TX_BUSY_IN));
   assign FREEZE_OUT = freeze;

   receive_shifter #(
      .BIT_CYCLES(BIT_CYCLES)
   ) u_shifter (
      .clk_in(SYS_CLK_IN),
      .rst_b_in(RST_B_IN),
      .serial_in(rx_line),
      .freeze_in(freeze),
      .busy_out(rx_busy),
      .done_out(rx_done),
      .data_out(rx_data),
      .frame_err_out(rx_err)
   );

   // ****************************************************************
   // APB decode; zero wait states, unmapped addresses give an error.
   // ****************************************************************
   assign hit = (PADDR_IN == GCR1_OFS) || (PADDR_IN == STAT_OFS) ||
                (PADDR_IN == MASK_OFS) || (PADDR_IN == RXDATA_OFS);
   assign setup_rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
   assign acc_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
   assign wr_gcr1 = acc_wr && (PADDR_IN == GCR1_OFS);
   assign wr_stat = acc_wr && (PADDR_IN == STAT_OFS);
   assign wr_mask = acc_wr && (PADDR_IN == MASK_OFS);
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;

   // ****************************************************************
   // Control register and long-frame tracking.
   // ****************************************************************
   assign frame_end = rx_done || TX_FRAME_DONE_IN;
   always_comb
   begin
      receive_transfer_enable_next = receive_transfer_enable_reg;
      run_on_suspend_next = run_on_suspend_reg;
      loop_next = loop_reg;
      lin_next = lin_reg;
      halt_next = halt_reg;
      long_next = long_reg;
      if (wr_gcr1)
      begin
         receive_transfer_enable_next = PWDATA_IN[RECEIVE_TRANSFER_ENABLE_BIT];
         run_on_suspend_next = PWDATA_IN[RUN_ON_SUSPEND_BIT];
         loop_next = PWDATA_IN[LOOP_BIT];
         lin_next = PWDATA_IN[LINMODE_BIT];
         if (PWDATA_IN[HALT_BIT] && lin_reg && long_reg)
            halt_next = 1'b1;
      end
      if (LONG_FRAME_START_IN && lin_reg)
         long_next = 1'b1;
      if (halt_reg && lin_reg && frame_end)
      begin
         long_next = 1'b0;
         halt_next = 1'b0;
      end
   end
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         receive_transfer_enable_reg <= 1'b0;
         run_on_suspend_reg <= 1'b0;
         loop_reg <= 1'b0;
         lin_reg <= 1'b0;
         halt_reg <= 1'b0;
         long_reg <= 1'b0;
      end
      else
      begin
         receive_transfer_enable_reg <= receive_transfer_enable_next;
         run_on_suspend_reg <= run_on_suspend_next;
         loop_reg <= loop_next;
         lin_reg <= lin_next;
         halt_reg <= halt_next;
         long_reg <= long_next;
      end
   end
   assign LONG_FRAME_ACTIVE_OUT = long_reg;

   // ****************************************************************
   // Receive transfer, sticky status, mask and interrupt.
   // ****************************************************************
   assign xfer = rx_done && receive_transfer_enable_reg;
   always_comb
   begin
      stat_set = '0;
      stat_set[ST_RXRDY] = xfer;
      stat_set[ST_RXERR] = xfer && rx_err;
      stat_set[ST_STOP] = halt_reg && lin_reg && frame_end;
      stat_next = stat_reg;
      if (wr_stat)
         stat_next = stat_reg & ~PWDATA_IN[STAT_W-1:0];
      stat_next = stat_next | stat_set;
      mask_next = wr_mask ? PWDATA_IN[STAT_W-1:0] : mask_reg;
      rxdata_next = xfer ? rx_data : rxdata_reg;
      bufwr_next = xfer;
   end
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         stat_reg <= STAT_RESET;
         mask_reg <= MASK_RESET;
         rxdata_reg <= RXDATA_RESET;
         bufwr_reg <= 1'b0;
      end
      else
      begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         rxdata_reg <= rxdata_next;
         bufwr_reg <= bufwr_next;
      end
   end
   always_comb
   begin
      irq_gate = '1;
      irq_gate[ST_RXRDY] = receive_transfer_enable_reg;
      irq_gate[ST_RXERR] = receive_transfer_enable_reg;
   end
   assign IRQ_OUT = |(stat_reg & mask_reg & irq_gate);
   assign RX_BUF_WRITE_OUT = bufwr_reg;
   assign RX_BUF_DATA_OUT = rxdata_reg;

   // ****************************************************************
   // Read data, registered in the setup cycle.
   // ****************************************************************
   always_comb
   begin
      gcr1_rd = '0;
      gcr1_rd[RECEIVE_TRANSFER_ENABLE_BIT] = receive_transfer_enable_reg;
      gcr1_rd[RUN_ON_SUSPEND_BIT] = run_on_suspend_reg;
      gcr1_rd[LOOP_BIT] = loop_reg;
      gcr1_rd[HALT_BIT] = halt_reg;
      gcr1_rd[LINMODE_BIT] = lin_reg;
      prdata_next = prdata_reg;
      if (setup_rd)
      begin
         unique case (PADDR_IN)
            GCR1_OFS: prdata_next = gcr1_rd;
            STAT_OFS: prdata_next = {{(32-STAT_W){1'b0}}, stat_reg};
            MASK_OFS: prdata_next = {{(32-STAT_W){1'b0}}, mask_reg};
            RXDATA_OFS: prdata_next = {24'h000000, rxdata_reg};
            default: prdata_next = PRDATA_RESET;
         endcase
      end
   end
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (!RST_B_IN)
         prdata_reg <= PRDATA_RESET;
      else
         prdata_reg <= prdata_next;
   end
   assign PRDATA_OUT = prdata_reg;

   // ****************************************************************
   // Assertions and covers.
   // ****************************************************************
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   a_drop_when_off: assert property (rx_done && !receive_transfer_enable_reg |=> !RX_BUF_WRITE_OUT)
      else $error("Frame stored while receive disabled.");
   a_store_when_on: assert property (rx_done && receive_transfer_enable_reg |=>
      RX_BUF_WRITE_OUT && RX_BUF_DATA_OUT == $past(rx_data))
      else $error("Enabled frame not stored.");
   a_status_frozen: assert property (rx_done && !receive_transfer_enable_reg && !wr_stat |=>
      stat_reg[ST_RXERR:ST_RXRDY] == $past(stat_reg[ST_RXERR:ST_RXRDY]))
      else $error("Status changed by disabled receive.");
   a_irq_suppress: assert property (!receive_transfer_enable_reg && !(stat_reg[ST_STOP] && mask_reg[ST_STOP])
      |-> !IRQ_OUT)
      else $error("Receive interrupt while disabled.");
   a_shift_starts: assert property (!receive_transfer_enable_reg && !freeze && !rx_busy && !rx_line |=> rx_busy)
      else $error("Shifter idle while receive disabled.");
   a_rsvd_zero: assert property (setup_rd && PADDR_IN == GCR1_OFS |=>
      PRDATA_OUT[23:18] == 6'h00 && PRDATA_OUT[15:14] == 2'h0)
      else $error("Reserved bits read nonzero.");
   a_freeze_now: assert property (DEBUG_SUSPEND_IN && !run_on_suspend_reg |-> FREEZE_OUT
      ##1 (!FREEZE_OUT || $stable(rx_busy)))
      else $error("Suspend did not freeze.");
   a_run_finish: assert property (DEBUG_SUSPEND_IN && run_on_suspend_reg && (rx_busy || TX_BUSY_IN)
      |-> !FREEZE_OUT)
      else $error("Froze before transfers ended.");
   a_loop_pins: assert property (loop_reg |-> SERIAL_OUT_PIN_OUT && !SERIAL_IN_PIN_OE_OUT
      && rx_line == TX_SERIAL_IN)
      else $error("Loopback pins wrong.");
   a_halt_guard: assert property (wr_gcr1 && !halt_reg && !(lin_reg && long_reg) |=> !halt_reg)
      else $error("Stop bit written outside long frame.");
   a_halt_clear: assert property (halt_reg && lin_reg && frame_end |=>
      !halt_reg && !LONG_FRAME_ACTIVE_OUT && stat_reg[ST_STOP])
      else $error("Long frame not stopped.");
   c_stored: cover property (xfer);
   c_dropped: cover property (rx_done && !receive_transfer_enable_reg);
   c_halted: cover property (halt_reg ##1 !halt_reg);
   c_frozen: cover property (FREEZE_OUT && rx_busy);
endmodule

// file: tb/serial_node_model.sv
// Remote serial node that drives 8N1 characters onto a serial line.
`timescale 1ns/1ns
module serial_node_model
#(
   parameter int BIT_CYCLES = 4
)
(
   input wire logic clk_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // ****************************************************************
   // Sends start bit, eight data bits LSB first, then the stop bit.
   // ****************************************************************
   task automatic send(input logic [7:0] data);
      logic [9:0] bits;
      bits = {1'b1, data, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk_in);
         line_out <= bits[i];
         repeat (BIT_CYCLES - 1) @(posedge clk_in);
      end
   endtask
   // ****************************************************************
   // Holds the line at a fixed level between characters.
   // ****************************************************************
   task automatic hold(input logic level);
      @(posedge clk_in);
      line_out <= level;
   endtask
endmodule

// file: tb/lin_sci_rx_gate_loop_debug_ctrl_tb_top.sv
// Self-checking bench for receive gating, loopback, suspend and long-frame stop.
`timescale 1ns/1ns
module lin_sci_rx_gate_loop_debug_ctrl_tb_top;
   import lin_gate_pkg::*;
   localparam int BITS = 4;
   localparam int LIMIT = 20000;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rx_pin, rx_oe, tx_pin;
   logic tx_ser, tx_busy, tx_done, lf_start, susp, freeze, buf_wr, lf_active, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] buf_data;
   int n_mismatch, n_compared, n_store, cycles;
   lin_sci_rx_gate_loop_debug_ctrl #(.BIT_CYCLES(BITS)) dut_u (.SYS_CLK_IN(clk),
      .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .SERIAL_IN_PIN_IN(rx_pin), .SERIAL_IN_PIN_OE_OUT(rx_oe),
      .SERIAL_OUT_PIN_OUT(tx_pin), .TX_SERIAL_IN(tx_ser), .TX_BUSY_IN(tx_busy),
      .TX_FRAME_DONE_IN(tx_done), .LONG_FRAME_START_IN(lf_start),
      .DEBUG_SUSPEND_IN(susp), .FREEZE_OUT(freeze), .RX_BUF_WRITE_OUT(buf_wr),
      .RX_BUF_DATA_OUT(buf_data), .LONG_FRAME_ACTIVE_OUT(lf_active), .IRQ_OUT(irq));
   serial_node_model #(.BIT_CYCLES(BITS)) node_u (.clk_in(clk), .line_out(rx_pin));
   serial_node_model #(.BIT_CYCLES(BITS)) txsrc_u (.clk_in(clk), .line_out(tx_ser));
   // ****************************************************************
   // Clock, cycle limit and store pulse counting.
   // ****************************************************************
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (buf_wr === 1'b1)
         n_store++;
      if (cycles == LIMIT)
      begin
         n_mismatch++;
         end_sim();
      end
   end
   // ****************************************************************
   // Verdict, comparison and bus tasks.
   // ****************************************************************
   task automatic end_sim();
      if (n_mismatch == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
      apb(1'b1, addr, wdata);
   endtask
   task automatic rchk(input string name, input logic [11:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000);
      chk(name, exp, rd);
   endtask
   task automatic pulse(input logic sel);
      @(posedge clk);
      tx_done <= sel;
      lf_start <= !sel;
      @(posedge clk);
      tx_done <= 1'b0;
      lf_start <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic frame_gap();
      repeat (10) @(posedge clk);
   endtask
   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial
   begin
      {rst_b, psel, penable, pwrite, tx_busy, tx_done, lf_start, susp} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rchk("gcr1_reset", GCR1_OFS, 32'h0000_0000);
      chk("mapped_err", 32'h0, {31'h0, err});
      rchk("stat_reset", STAT_OFS, 32'h0000_0000);
      rchk("rxdata_reset", RXDATA_OFS, 32'h0000_0000);
      apb(1'b0, 12'h0f0, 32'h0000_0000);
      chk("unmapped_err", 32'h1, {31'h0, err});
      wr(GCR1_OFS, 32'hffff_ffff);
      rchk("gcr1_reserved", GCR1_OFS, 32'h0103_0040);
      wr(GCR1_OFS, 32'h0000_0000);
      wr(MASK_OFS, 32'h0000_0007);
      node_u.send(8'ha5);
      frame_gap();
      chk("store_off", 32'h0, n_store);
      rchk("stat_off", STAT_OFS, 32'h0000_0000);
      chk("irq_off", 32'h0, {31'h0, irq});
      rchk("rxdata_off", RXDATA_OFS, 32'h0000_0000);
      wr(GCR1_OFS, 32'h0100_0000);
      node_u.send(8'h3c);
      frame_gap();
      chk("store_on", 32'h1, n_store);
      chk("buf_on", 32'h3c, {24'h0, buf_data});
      rchk("stat_on", STAT_OFS, 32'h0000_0001);
      chk("irq_on", 32'h1, {31'h0, irq});
      wr(STAT_OFS, 32'h0000_0001);
      @(posedge clk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      wr(GCR1_OFS, 32'h0000_0000);
      fork
         node_u.send(8'h69);
         begin
            repeat (12) @(posedge clk);
            wr(GCR1_OFS, 32'h0100_0000);
         end
      join
      frame_gap();
      chk("store_mid_set", 32'h2, n_store);
      chk("buf_mid_set", 32'h69, {24'h0, buf_data});
      fork
         node_u.send(8'h96);
         begin
            repeat (12) @(posedge clk);
            wr(GCR1_OFS, 32'h0000_0000);
         end
      join
      frame_gap();
      chk("store_mid_clr", 32'h2, n_store);
      wr(GCR1_OFS, 32'h0101_0000);
      node_u.hold(1'b0);
      fork
         txsrc_u.send(8'hc3);
         begin
            repeat (3) @(posedge clk);
            chk("tx_pin_loop", 32'h1, {31'h0, tx_pin});
            chk("rx_oe_loop", 32'h0, {31'h0, rx_oe});
         end
      join
      frame_gap();
      chk("store_loop", 32'h3, n_store);
      chk("buf_loop", 32'hc3, {24'h0, buf_data});
      node_u.hold(1'b1);
      repeat (4) @(posedge clk);
      wr(GCR1_OFS, 32'h0000_0000);
      txsrc_u.hold(1'b0);
      @(posedge clk);
      chk("tx_pin_pass", 32'h0, {31'h0, tx_pin});
      txsrc_u.hold(1'b1);
      susp <= 1'b1;
      @(posedge clk);
      chk("freeze_stop", 32'h1, {31'h0, freeze});
      wr(GCR1_OFS, 32'h0002_0000);
      tx_busy <= 1'b1;
      @(posedge clk);
      chk("freeze_busy", 32'h0, {31'h0, freeze});
      tx_busy <= 1'b0;
      @(posedge clk);
      chk("freeze_idle", 32'h1, {31'h0, freeze});
      susp <= 1'b0;
      @(posedge clk);
      chk("freeze_off", 32'h0, {31'h0, freeze});
      pulse(1'b0);
      chk("lf_sci", 32'h0, {31'h0, lf_active});
      wr(GCR1_OFS, 32'h0000_2040);
      rchk("halt_idle", GCR1_OFS, 32'h0000_0040);
      pulse(1'b0);
      chk("lf_on", 32'h1, {31'h0, lf_active});
      wr(GCR1_OFS, 32'h0000_0040);
      rchk("halt_zero", GCR1_OFS, 32'h0000_0040);
      chk("lf_hold", 32'h1, {31'h0, lf_active});
      wr(GCR1_OFS, 32'h0000_2040);
      rchk("halt_set", GCR1_OFS, 32'h0000_2040);
      pulse(1'b1);
      chk("lf_end", 32'h0, {31'h0, lf_active});
      rchk("halt_auto", GCR1_OFS, 32'h0000_0040);
      rchk("stat_stop", STAT_OFS, 32'h0000_0005);
      chk("irq_stop", 32'h1, {31'h0, irq});
      wr(MASK_OFS, 32'h0000_0000);
      @(posedge clk);
      chk("irq_mask", 32'h0, {31'h0, irq});
      end_sim();
   end
endmodule
